// file: pkg/serial1_cfg.svh
// Register offsets, field positions, reset values and timing counts of serial port one
`ifndef SERIAL1_CFG_SVH
`define SERIAL1_CFG_SVH
`define CTRL_OFFSET 8'hc0
`define DATA_OFFSET 8'hc1
`define SADDR_OFFSET 8'hc2
`define SADEN_OFFSET 8'hc3
`define AUX_OFFSET 8'hc4
`define CTRL_RESET 8'h00
`define SADDR_RESET 8'h00
`define SADEN_RESET 8'h00
`define AUX_RESET 8'h00
`define BIT_MODE_HIGH 7
`define BIT_MODE_LOW 6
`define BIT_MP_EN 5
`define BIT_RX_EN 4
`define BIT_TX_NINTH 3
`define BIT_RX_NINTH 2
`define BIT_TX_DONE 1
`define BIT_RX_DONE 0
`define BIT_FRAME_SEL 0
`define BIT_DOUBLE_RATE 1
`define BIT_PRIORITY 2
`define BIT_FE_STATUS 3
`define DIV_SYNC_SLOW 12
`define DIV_SYNC_FAST 4
`define DIV_MODE2_SLOW 64
`define DIV_MODE2_FAST 32
`define OVERSAMPLE 16
`define BAUD_RELOAD_RESET 16'h0044
`define BAUD_RELOAD_LO_OFFSET 8'hc5
`define BAUD_RELOAD_HI_OFFSET 8'hc6
`endif

// file: pkg/serial1_pkg.sv
// Types shared by serial port one
package serial1_pkg;
    typedef enum logic [1:0] {MODE_SYNC, MODE_ASYNC10, MODE_ASYNC11_FIXED, MODE_ASYNC11_VAR} serial_mode_e;
    typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} tx_state_e;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_e;
endpackage

// file: verilog/serial1_port.sv
// Serial port one with framing check, multiprocessor filter and slave address match
`timescale 1ns/10ps
`include "serial1_cfg.svh"

// Functional notes
// R1 - Mask ones select address bits compared against station address.
// R2 - All-zero mask makes every address a match.
// R3 - Software loads station address with own or broadcast address.
// R4 - Control bit 7 is mode-high or framing error, chosen by framing select.
// R5 - Framing error sets on bad stop bit, cleared only by software zero.
// R6 - Mode bits pick sync 8, async 10 variable, async 11 fixed, async 11 variable.
// R7 - Eleven-bit modes with multiprocessor on: ninth bit zero blocks receive flag.
// R8 - Ten-bit mode with multiprocessor on: bad stop bit blocks receive flag.
// R9 - Sync mode shifts at clock/12, or clock/4 with multiprocessor bit.
// R10 - Frames start only while receive enable is one.
// R11 - Eleven-bit modes send software transmit ninth bit, hardware never alters it.
// R12 - Receive ninth field takes ninth bit, or stop bit in ten-bit mode with multiprocessor off.
// R13 - Transmit flag sets after eighth sync bit or at stop start.
// R14 - Receive flag sets mid stop bit; sync mode never receives.
// R15 - Receive flag is cleared only by software writing zero.
// R16 - Priority bit one gives this port the high interrupt level.
// R17 - Data address reads receive register, writes load transmit buffer.
// R18 - Match when received address xor station, masked, equals zero.
module serial1_port
    import serial1_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Avalon-MM slave
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [7:0] writedata,
    output logic [7:0] readdata,
    output logic waitrequest,
    // Serial pins
    input wire logic rxd_in,
    output logic txd_out,
    output logic sync_data_out,
    output logic sync_data_oe,
    output logic sync_clock_out,
    // Interrupt request towards the controller
    output logic irq_rx,
    output logic irq_tx,
    output logic irq_high_priority
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] ctrl_reg;
        logic fe_reg;
        logic [7:0] saddr_reg;
        logic [7:0] saden_reg;
        logic [7:0] aux_reg;
        logic [15:0] reload_reg;
        logic [7:0] rx_data_reg;
        logic [7:0] readdata_reg;
        logic ack_reg;
        logic [1:0][8:0] buf_word;
        logic [1:0] buf_count;
        logic wait_reg;
        logic [15:0] baud_cnt;
        logic [3:0] tick_cnt;
        logic [5:0] sync_div;
        tx_state_e tx_state;
        logic [10:0] tx_shift;
        logic [3:0] tx_bits;
        logic [3:0] tx_phase;
        logic [1:0] tx_sync_half;
        rx_state_e rx_state;
        logic [8:0] rx_shift;
        logic [3:0] rx_bits;
        logic [3:0] rx_phase;
        logic rx_prev;
        logic txd;
        logic sdata;
        logic soe;
        logic sclk;
    } state_s;

    state_s s_reg;
    state_s s_next;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic addr_match(input logic [7:0] rx, input logic [7:0] sa, input logic [7:0] mk);
        addr_match = (((rx ^ sa) & mk) == 8'h00); // R1 R2 R18
    endfunction

    function automatic logic is_eleven(input serial_mode_e m);
        is_eleven = (m == MODE_ASYNC11_FIXED) || (m == MODE_ASYNC11_VAR);
    endfunction

    serial_mode_e mode;
    logic mode_high;
    logic access;
    logic wr_fire;
    logic tick16;
    logic sync_tick;
    logic [15:0] baud_limit;

    // R4: with framing select clear, bit 7 stores mode-high; with it set, bit 7 shows framing error
    assign mode_high = s_reg.ctrl_reg[`BIT_MODE_HIGH];
    assign mode = serial_mode_e'({mode_high, s_reg.ctrl_reg[`BIT_MODE_LOW]}); // R6
    assign access = (read || write) && !s_reg.ack_reg;
    // Writes land at the answer edge
    assign wr_fire = write && s_reg.ack_reg;

    always_comb
    begin
        if (mode == MODE_ASYNC11_FIXED)
        begin
            baud_limit = s_reg.aux_reg[`BIT_DOUBLE_RATE] ? 16'(`DIV_MODE2_FAST / `OVERSAMPLE - 1)
                                                         : 16'(`DIV_MODE2_SLOW / `OVERSAMPLE - 1); // R6
        end
        else
        begin
            baud_limit = s_reg.reload_reg;
        end
    end

    assign tick16 = (s_reg.baud_cnt >= baud_limit);
    // R9: sync half-period from the multiprocessor bit
    assign sync_tick = s_reg.ctrl_reg[`BIT_MP_EN] ? (s_reg.sync_div >= 6'(`DIV_SYNC_FAST / 2 - 1))
                                                 : (s_reg.sync_div >= 6'(`DIV_SYNC_SLOW / 2 - 1));

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic rx_done_set;
        logic tx_done_set;
        logic fe_set;
        logic push;
        logic pop;
        logic [8:0] head;
        logic [8:0] rx_word;
        logic stop_ok;
        logic accept;
        rx_done_set = 1'b0;
        tx_done_set = 1'b0;
        fe_set = 1'b0;
        push = 1'b0;
        pop = 1'b0;
        head = s_reg.buf_word[0];
        rx_word = 9'h000;
        stop_ok = 1'b0;
        accept = 1'b0;
        s_next = s_reg;
        s_next.ack_reg = access;
        s_next.wait_reg = !access;
        s_next.rx_prev = rxd_in;

        // Bit-rate dividers
        s_next.baud_cnt = tick16 ? 16'h0000 : s_reg.baud_cnt + 16'h0001;
        s_next.sync_div = sync_tick ? 6'h00 : s_reg.sync_div + 6'h01;

        // Transmitter, drains the two-entry buffer
        case (s_reg.tx_state)
            TX_IDLE:
            begin
                s_next.txd = 1'b1;
                s_next.soe = 1'b0;
                s_next.sclk = 1'b1;
                if (s_reg.buf_count != 2'd0)
                begin
                    pop = 1'b1;
                    s_next.tx_bits = 4'd0;
                    s_next.tx_phase = 4'd0;
                    s_next.tx_sync_half = 2'd0;
                    // R11: ninth bit is the software-held transmit ninth bit
                    s_next.tx_shift = is_eleven(mode) ? {1'b1, s_reg.ctrl_reg[`BIT_TX_NINTH], head[7:0], 1'b0}
                                                      : {2'b11, head[7:0], 1'b0};
                    if (mode == MODE_SYNC)
                    begin
                        s_next.tx_shift = {3'b111, head[7:0]};
                    end
                    s_next.tx_state = TX_SHIFT;
                end
            end
            TX_SHIFT:
            begin
                if (mode == MODE_SYNC)
                begin
                    s_next.soe = 1'b1;
                    s_next.sdata = s_reg.tx_shift[0];
                    if (sync_tick)
                    begin
                        s_next.sclk = ~s_reg.sclk;
                        if (s_reg.sclk)
                        begin
                            s_next.tx_sync_half = 2'd1;
                        end
                        else if (s_reg.tx_sync_half == 2'd1)
                        begin
                            s_next.tx_shift = {1'b1, s_reg.tx_shift[10:1]};
                            s_next.tx_bits = s_reg.tx_bits + 4'd1;
                            if (s_reg.tx_bits == 4'd7)
                            begin
                                tx_done_set = 1'b1; // R13
                                s_next.tx_state = TX_IDLE;
                            end
                        end
                    end
                end
                else if (tick16)
                begin
                    s_next.txd = s_reg.tx_shift[0];
                    s_next.tx_phase = s_reg.tx_phase + 4'd1;
                    // Flag rises with the stop bit
                    if (s_reg.tx_phase == 4'd0 && s_reg.tx_bits == (is_eleven(mode) ? 4'd10 : 4'd9))
                    begin
                        tx_done_set = 1'b1; // R13
                    end
                    if (s_reg.tx_phase == 4'd15)
                    begin
                        s_next.tx_shift = {1'b1, s_reg.tx_shift[10:1]};
                        s_next.tx_bits = s_reg.tx_bits + 4'd1;
                        if (s_reg.tx_bits == (is_eleven(mode) ? 4'd10 : 4'd9))
                        begin
                            s_next.tx_state = TX_IDLE;
                        end
                    end
                end
            end
            default:
            begin
                s_next.tx_state = TX_IDLE;
            end
        endcase

        // Receiver; frames start only with receive enable set
        case (s_reg.rx_state)
            RX_IDLE:
            begin
                if (s_reg.ctrl_reg[`BIT_RX_EN] && mode != MODE_SYNC && s_reg.rx_prev && !rxd_in) // R10
                begin
                    s_next.rx_state = RX_START;
                    s_next.rx_phase = 4'd0;
                    s_next.rx_bits = 4'd0;
                end
            end
            RX_START:
            begin
                if (tick16)
                begin
                    s_next.rx_phase = s_reg.rx_phase + 4'd1;
                    if (s_reg.rx_phase == 4'd7 && rxd_in)
                    begin
                        s_next.rx_state = RX_IDLE;
                    end
                    else if (s_reg.rx_phase == 4'd15)
                    begin
                        s_next.rx_state = RX_DATA;
                    end
                end
            end
            RX_DATA:
            begin
                if (tick16)
                begin
                    s_next.rx_phase = s_reg.rx_phase + 4'd1;
                    if (s_reg.rx_phase == 4'd7)
                    begin
                        s_next.rx_shift = {rxd_in, s_reg.rx_shift[8:1]};
                        s_next.rx_bits = s_reg.rx_bits + 4'd1;
                    end
                    if (s_reg.rx_phase == 4'd15 && s_reg.rx_bits == (is_eleven(mode) ? 4'd9 : 4'd8))
                    begin
                        s_next.rx_state = RX_STOP;
                    end
                end
            end
            RX_STOP:
            begin
                if (tick16 && s_reg.rx_phase == 4'd7)
                begin
                    s_next.rx_state = RX_IDLE;
                    stop_ok = rxd_in;
                    rx_word = is_eleven(mode) ? s_reg.rx_shift : {stop_ok, s_reg.rx_shift[8:1]};
                    fe_set = !stop_ok; // R5
                    accept = 1'b1;
                    if (s_reg.ctrl_reg[`BIT_MP_EN])
                    begin
                        if (is_eleven(mode))
                        begin
                            accept = rx_word[8] && addr_match(rx_word[7:0], s_reg.saddr_reg, s_reg.saden_reg); // R7 R1
                        end
                        else
                        begin
                            accept = stop_ok; // R8
                        end
                    end
                    if (accept)
                    begin
                        rx_done_set = 1'b1; // R14
                        s_next.rx_data_reg = rx_word[7:0];
                        if (is_eleven(mode) || !s_reg.ctrl_reg[`BIT_MP_EN])
                        begin
                            s_next.ctrl_reg[`BIT_RX_NINTH] = rx_word[8]; // R12
                        end
                    end
                end
                else if (tick16)
                begin
                    s_next.rx_phase = s_reg.rx_phase + 4'd1;
                end
            end
            default:
            begin
                s_next.rx_state = RX_IDLE;
            end
        endcase

        // Register writes; hardware sets win over software clears
        if (wr_fire)
        begin
            case (address)
                `CTRL_OFFSET:
                begin
                    s_next.ctrl_reg[6:0] = writedata[6:0];
                    if (s_reg.aux_reg[`BIT_FRAME_SEL])
                    begin
                        if (!writedata[`BIT_MODE_HIGH])
                        begin
                            s_next.fe_reg = 1'b0; // R5
                        end
                    end
                    else
                    begin
                        s_next.ctrl_reg[`BIT_MODE_HIGH] = writedata[`BIT_MODE_HIGH]; // R4
                    end
                end
                `DATA_OFFSET:
                begin
                    push = (s_reg.buf_count != 2'd2); // R17
                end
                `SADDR_OFFSET:
                begin
                    s_next.saddr_reg = writedata; // R3
                end
                `SADEN_OFFSET:
                begin
                    s_next.saden_reg = writedata;
                end
                `AUX_OFFSET:
                begin
                    s_next.aux_reg = {5'h00, writedata[2:0]};
                end
                `BAUD_RELOAD_LO_OFFSET:
                begin
                    s_next.reload_reg[7:0] = writedata;
                end
                `BAUD_RELOAD_HI_OFFSET:
                begin
                    s_next.reload_reg[15:8] = writedata;
                end
                default:
                begin
                end
            endcase
        end
        if (rx_done_set)
        begin
            s_next.ctrl_reg[`BIT_RX_DONE] = 1'b1; // R15
        end
        if (tx_done_set)
        begin
            s_next.ctrl_reg[`BIT_TX_DONE] = 1'b1;
        end
        if (fe_set)
        begin
            s_next.fe_reg = 1'b1;
        end

        // Two-entry transmit buffer
        if (pop)
        begin
            s_next.buf_word[0] = s_reg.buf_word[1];
        end
        if (push)
        begin
            s_next.buf_word[(pop ? s_reg.buf_count - 2'd1 : s_reg.buf_count) == 2'd0 ? 0 : 1] = {1'b0, writedata};
        end
        s_next.buf_count = s_reg.buf_count + (push ? 2'd1 : 2'd0) - (pop ? 2'd1 : 2'd0);

        // Read data
        if (access && read)
        begin
            case (address)
                `CTRL_OFFSET:
                    s_next.readdata_reg = s_reg.aux_reg[`BIT_FRAME_SEL] ? {s_reg.fe_reg, s_reg.ctrl_reg[6:0]}
                                                                       : s_reg.ctrl_reg; // R4
                `DATA_OFFSET: s_next.readdata_reg = s_reg.rx_data_reg; // R17
                `SADDR_OFFSET: s_next.readdata_reg = s_reg.saddr_reg;
                `SADEN_OFFSET: s_next.readdata_reg = s_reg.saden_reg;
                `AUX_OFFSET: s_next.readdata_reg = {4'h0, s_reg.fe_reg, s_reg.aux_reg[2:0]};
                `BAUD_RELOAD_LO_OFFSET: s_next.readdata_reg = s_reg.reload_reg[7:0];
                `BAUD_RELOAD_HI_OFFSET: s_next.readdata_reg = s_reg.reload_reg[15:8];
                default: s_next.readdata_reg = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_reg <= '0;
            s_reg.reload_reg <= `BAUD_RELOAD_RESET;
            s_reg.txd <= 1'b1;
            s_reg.sclk <= 1'b1;
            s_reg.rx_prev <= 1'b1;
            s_reg.wait_reg <= 1'b1;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Answer one cycle after the request; stall while the buffer is full is not needed since a full write drops
    assign waitrequest = s_reg.wait_reg;
    assign readdata = s_reg.readdata_reg;
    assign txd_out = s_reg.txd;
    assign sync_data_out = s_reg.sdata;
    assign sync_data_oe = s_reg.soe;
    assign sync_clock_out = s_reg.sclk;
    assign irq_rx = s_reg.ctrl_reg[`BIT_RX_DONE];
    assign irq_tx = s_reg.ctrl_reg[`BIT_TX_DONE];
    assign irq_high_priority = s_reg.aux_reg[`BIT_PRIORITY]; // R16

endmodule

// file: testbench/serial1_port_assertions.sv
// Checker of the bus handshake and flag behaviour of serial port one
`timescale 1ns/10ps
`include "serial1_cfg.svh"
module serial1_port_checker (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Register bus
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [7:0] writedata,
    input wire logic [7:0] readdata,
    input wire logic waitrequest,
    // Line and flags
    input wire logic txd_out,
    input wire logic irq_rx,
    input wire logic irq_tx,
    input wire logic irq_high_priority
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    // ----
    // Bus handshake
    // ----
    sequence s_req_start;
        $rose(read || write);
    endsequence
    sequence s_ack_once;
        !waitrequest ##1 waitrequest;
    endsequence
    property p_handshake;
        s_req_start |=> s_ack_once;
    endproperty
    a_handshake: assert property (p_handshake) else $error("bus answer not one cycle after request");
    property p_idle_no_ack;
        !(read || write) |=> waitrequest;
    endproperty
    a_idle_no_ack: assert property (p_idle_no_ack) else $error("answer without request");
    property p_unmapped;
        read && !waitrequest && address == 8'hd0 |-> readdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    // Read data only moves when a read was presented
    property p_readdata_hold;
        !$past(read) |-> $stable(readdata);
    endproperty
    a_readdata_hold: assert property (p_readdata_hold) else $error("read data moved");
    // ----
    // Flags and priority
    // ----
    sequence s_write_to(logic [7:0] where);
        write && !waitrequest && address == where;
    endsequence
    property p_priority;
        $changed(irq_high_priority) |-> $past(write && !waitrequest && address == `AUX_OFFSET)
            && irq_high_priority == $past(writedata[`BIT_PRIORITY]);
    endproperty
    a_priority: assert property (p_priority) else $error("priority level changed without write");
    property p_rx_clear;
        $fell(irq_rx) |-> $past(write && !waitrequest && address == `CTRL_OFFSET && !writedata[`BIT_RX_DONE]);
    endproperty
    a_rx_clear: assert property (p_rx_clear) else $error("receive flag cleared by hardware");
    property p_tx_clear;
        $fell(irq_tx) |-> $past(write && !waitrequest && address == `CTRL_OFFSET && !writedata[`BIT_TX_DONE]);
    endproperty
    a_tx_clear: assert property (p_tx_clear) else $error("transmit flag cleared by hardware");
    property p_tx_stop;
        $rose(irq_tx) |-> ##[0:1] txd_out;
    endproperty
    a_tx_stop: assert property (p_tx_stop) else $error("transmit flag not at stop bit");
    c_data_write: cover property (s_write_to(`DATA_OFFSET));
endmodule

bind serial1_port serial1_port_checker checker_inst (.clock, .rst_b, .address, .read, .write, .writedata,
    .readdata, .waitrequest, .txd_out, .irq_rx, .irq_tx, .irq_high_priority);

// file: testbench/remote_station.sv
// Model of a remote station on the serial lines of port one
`timescale 1ns/10ps
module remote_station #(
    parameter int BIT_CLKS = 32
) (
    // Clock
    input wire logic clock,
    // Serial lines
    input wire logic txd_line,
    output logic rxd_line
);
    logic [8:0] got_q[$];
    logic [8:0] shift_reg;
    initial rxd_line = 1'h1;
    // Start, eight data bits lsb first, ninth bit, stop; the line idles high
    task automatic send_frame(input logic [7:0] data, input logic ninth, input logic stop);
        logic [10:0] frame;
        frame = {stop, ninth, data, 1'h0};
        for (int i = 0; i < 11; i++)
        begin
            rxd_line <= frame[i];
            repeat (BIT_CLKS) @(posedge clock);
        end
        rxd_line <= 1'h1;
        @(posedge clock);
    endtask
    // Samples each bit at its middle, keeps data and ninth bit
    always
    begin
        @(negedge txd_line);
        repeat (BIT_CLKS / 2) @(posedge clock);
        for (int i = 0; i < 9; i++)
        begin
            repeat (BIT_CLKS) @(posedge clock);
            shift_reg[i] = txd_line;
        end
        got_q.push_back(shift_reg);
        repeat (BIT_CLKS) @(posedge clock);
    end
endmodule

// file: testbench/serial1_port_test.sv
// Self-checking testbench of serial port one
`timescale 1ns/10ps
`include "serial1_cfg.svh"
module serial1_port_test;
    logic clock, rst_b, read, write, rxd_in, waitrequest, txd_out, sync_data_out, sync_data_oe, sync_clock_out;
    logic irq_rx, irq_tx, irq_high_priority;
    logic [7:0] address, writedata, readdata, rd;
    int fails, samples_checked, cycles;
    time t0;
    serial1_port DUT (.clock, .rst_b, .address, .read, .write, .writedata, .readdata, .waitrequest, .rxd_in,
        .txd_out, .sync_data_out, .sync_data_oe, .sync_clock_out, .irq_rx, .irq_tx, .irq_high_priority);
    remote_station #(.BIT_CLKS(32)) far (.clock, .txd_line(txd_out), .rxd_line(rxd_in));
    initial
    begin
        clock = 1'h0;
        forever #4 clock = ~clock;
    end
    always @(posedge clock)
    begin
        cycles = cycles + 1;
        if (cycles == 20000)
        begin
            fails = fails + 1;
            summarize();
        end
    end
    // ----
    // Helpers
    // ----
    task automatic summarize;
        $display("fails %0d samples_checked %0d", fails, samples_checked);
        if (fails == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Holds the request until waitrequest is sampled low, then leaves one idle edge
    task automatic bus(input logic wr, input logic [7:0] addr, input logic [7:0] data);
        read <= ~wr;
        write <= wr;
        address <= addr;
        writedata <= data;
        @(posedge clock);
        while (waitrequest !== 1'h0) @(posedge clock);
        rd = readdata;
        read <= 1'h0;
        write <= 1'h0;
        @(posedge clock);
    endtask
    // ----
    // Scenarios
    // ----
    task automatic t_registers;
        bus(1'h0, `CTRL_OFFSET, 8'h00);
        check("control reset", `CTRL_RESET, rd);
        bus(1'h0, `SADEN_OFFSET, 8'h00);
        check("mask reset", `SADEN_RESET, rd);
        bus(1'h1, 8'hd0, 8'h5a);
        bus(1'h0, 8'hd0, 8'h00);
        check("unmapped", 8'h00, rd);
        bus(1'h1, `SADDR_OFFSET, 8'ha5);
        bus(1'h0, `SADDR_OFFSET, 8'h00);
        check("station", 8'ha5, rd);
        bus(1'h1, `AUX_OFFSET, 8'h04);
        check("priority high", 8'h01, irq_high_priority);
        bus(1'h1, `AUX_OFFSET, 8'h02);
        check("priority low", 8'h00, irq_high_priority);
        $display("registers done");
    endtask
    task automatic t_transmit;
        bus(1'h1, `CTRL_OFFSET, 8'h88);
        bus(1'h1, `DATA_OFFSET, 8'h3c);
        bus(1'h1, `DATA_OFFSET, 8'hc3);
        repeat (800) @(posedge clock);
        check("frames sent", 8'h02, 8'(far.got_q.size()));
        check("first byte", 8'h3c, far.got_q[0][7:0]);
        check("first ninth", 8'h01, far.got_q[0][8]);
        check("second byte", 8'hc3, far.got_q[1][7:0]);
        bus(1'h0, `CTRL_OFFSET, 8'h00);
        check("control after send", 8'h8a, rd);
        bus(1'h1, `CTRL_OFFSET, 8'h88);
        check("transmit flag clear", 8'h00, irq_tx);
        $display("transmit done");
    endtask
    task automatic t_match;
        bus(1'h1, `SADDR_OFFSET, 8'h12);
        bus(1'h1, `SADEN_OFFSET, 8'hff);
        bus(1'h1, `CTRL_OFFSET, 8'hb0);
        far.send_frame(8'h34, 1'h1, 1'h1);
        check("other address", 8'h00, irq_rx);
        far.send_frame(8'h12, 1'h0, 1'h1);
        check("ninth zero", 8'h00, irq_rx);
        far.send_frame(8'h12, 1'h1, 1'h1);
        check("own address", 8'h01, irq_rx);
        bus(1'h0, `DATA_OFFSET, 8'h00);
        check("address byte", 8'h12, rd);
        bus(1'h0, `CTRL_OFFSET, 8'h00);
        check("ninth captured", 8'hb5, rd);
        bus(1'h1, `CTRL_OFFSET, 8'hb0);
        bus(1'h1, `SADEN_OFFSET, 8'h0f);
        far.send_frame(8'hf2, 1'h1, 1'h1);
        check("masked match", 8'h01, irq_rx);
        bus(1'h1, `CTRL_OFFSET, 8'hb0);
        bus(1'h1, `SADEN_OFFSET, 8'h00);
        far.send_frame(8'h99, 1'h1, 1'h1);
        check("any address", 8'h01, irq_rx);
        $display("address match done");
    endtask
    task automatic t_ten_bit;
        bus(1'h1, `BAUD_RELOAD_LO_OFFSET, 8'h01);
        bus(1'h1, `BAUD_RELOAD_HI_OFFSET, 8'h00);
        bus(1'h1, `CTRL_OFFSET, 8'h40);
        far.send_frame(8'h5a, 1'h1, 1'h1);
        check("receive off", 8'h00, irq_rx);
        bus(1'h1, `CTRL_OFFSET, 8'h70);
        far.send_frame(8'h5a, 1'h0, 1'h1);
        check("bad stop filtered", 8'h00, irq_rx);
        bus(1'h1, `CTRL_OFFSET, 8'h50);
        far.send_frame(8'h5a, 1'h1, 1'h1);
        check("ten bit flag", 8'h01, irq_rx);
        bus(1'h0, `CTRL_OFFSET, 8'h00);
        check("stop captured", 8'h55, rd);
        bus(1'h1, `AUX_OFFSET, 8'h03);
        bus(1'h1, `CTRL_OFFSET, 8'h50);
        bus(1'h0, `CTRL_OFFSET, 8'h00);
        check("error cleared", 8'h00, rd & 8'h80);
        far.send_frame(8'h0f, 1'h0, 1'h1);
        bus(1'h1, `CTRL_OFFSET, 8'hd0);
        bus(1'h0, `CTRL_OFFSET, 8'h00);
        check("error set", 8'h80, rd & 8'h80);
        bus(1'h1, `CTRL_OFFSET, 8'h50);
        bus(1'h0, `CTRL_OFFSET, 8'h00);
        check("error zeroed", 8'h00, rd & 8'h80);
        bus(1'h1, `AUX_OFFSET, 8'h02);
        bus(1'h1, `CTRL_OFFSET, 8'hd0);
        far.send_frame(8'h66, 1'h0, 1'h1);
        bus(1'h0, `CTRL_OFFSET, 8'h00);
        check("mode three", 8'hd1, rd);
        $display("ten bit done");
    endtask
    task automatic t_sync(input logic [7:0] ctrl, input logic [7:0] div);
        logic [7:0] got;
        got = 8'h00;
        bus(1'h1, `CTRL_OFFSET, ctrl);
        bus(1'h1, `DATA_OFFSET, 8'ha5);
        for (int i = 0; i < 8; i++)
        begin
            @(posedge sync_clock_out);
            got[i] = sync_data_out;
            if (i == 0)
                t0 = $time;
            if (i == 1)
                check("shift period", div, 8'(($time - t0) / 8));
        end
        check("drive enable", 8'h01, sync_data_oe);
        check("shift data", 8'ha5, got);
        repeat (div) @(posedge clock);
        check("shift done", 8'h01, irq_tx);
        bus(1'h1, `CTRL_OFFSET, ctrl);
        $display("sync done");
    endtask
    initial
    begin
        rst_b = 1'h0;
        read = 1'h0;
        write = 1'h0;
        address = 8'h00;
        writedata = 8'h00;
        fails = 0;
        samples_checked = 0;
        cycles = 0;
        repeat (20) @(posedge clock);
        rst_b <= 1'h1;
        @(posedge clock);
        t_registers();
        t_transmit();
        t_match();
        t_ten_bit();
        t_sync(8'h00, 8'h0c);
        t_sync(8'h20, 8'h04);
        summarize();
    end
endmodule
